// ===== verilog/oasp_map.vh
// constants shared by the or / carry-or / stack pull execute unit
// assumes an 8-bit core with a 256-byte direct space and a 256-bit bit space
`ifndef OASP_MAP_VH
`define OASP_MAP_VH

// opcodes handled by this unit
`define OASP_OP_ACC_REG_HI 5'h09
`define OASP_OP_ACC_DIR 8'h45
`define OASP_OP_ACC_IND_HI 7'h23
`define OASP_OP_ACC_IMM 8'h44
`define OASP_OP_DIR_IMM 8'h43
`define OASP_OP_C_BIT 8'h72
`define OASP_OP_C_NBIT 8'ha0
`define OASP_OP_POP 8'hd0

// direct addresses of the state kept inside this unit
`define OASP_ADDR_ACC 8'he0
`define OASP_ADDR_SP 8'h81
`define OASP_ADDR_PSW 8'hd0

// status word field positions
`define OASP_PSW_CY 7
`define OASP_PSW_RS_HI 4
`define OASP_PSW_RS_LO 3
`define OASP_PSW_OV 2
`define OASP_PSW_P 0

// reset values
`define OASP_RST_ACC 8'h00
`define OASP_RST_SP 8'h07
`define OASP_RST_PSW 8'h00

// bit addresses from this value upward select bits of byte registers
`define OASP_BIT_SFR_BASE 8'h80

// clock cycles spent in execution per instruction class
`define OASP_CYC_SHORT 1
`define OASP_CYC_LONG 2

`endif

// ===== verilog/oasp_alu.v
// byte or unit and bit operand picker for the execute unit
// assumes purely combinational use by the main execute module
`timescale 1ns/1ps

module oasp_alu #(
  parameter W = 8
) (
  // byte operands
  input wire [W-1:0] opa_i,
  input wire [W-1:0] opb_i,
  // bit operand source byte and selection
  input wire [W-1:0] bit_byte_i,
  input wire [2:0] bit_sel_i,
  input wire bit_inv_i,
  // results
  output wire [W-1:0] or_res_o,
  output wire bit_val_o
);

  // bitwise or of the two byte operands
  assign or_res_o = opa_i | opb_i;

  // complement only the copy used as source; the stored bit is never written
  assign bit_val_o = bit_byte_i[bit_sel_i] ^ bit_inv_i;

endmodule

// ===== verilog/oasp_exec.v
// execute unit for byte or, carry or and stack pull instructions
// assumes the direct space, internal ram and bit space answer within the
// same cycle in which the address and read strobe are presented
`timescale 1ns/1ps
`include "oasp_map.vh"

module oasp_exec #(
  parameter W = 8
) (
  // clock, reset and enable
  input wire clock_i,
  input wire nrst_i,
  input wire ce_i,
  // instruction issue
  input wire start_i,
  input wire [7:0] opcode_i,
  input wire [7:0] byte2_i,
  input wire [7:0] byte3_i,
  // indirect pointer registers of the current bank
  input wire [W-1:0] ptr0_i,
  input wire [W-1:0] ptr1_i,
  // read answers
  input wire [W-1:0] dir_rdata_i,
  input wire [W-1:0] ram_rdata_i,
  input wire [W-1:0] bit_byte_i,
  // instruction status
  output reg busy_o,
  output reg done_o,
  output reg illegal_o,
  // direct space access
  output reg [7:0] dir_addr_o,
  output reg dir_rd_o,
  output reg dir_latch_o,
  output reg dir_wr_o,
  output reg [W-1:0] dir_wdata_o,
  // internal ram access
  output reg [7:0] ram_addr_o,
  output reg ram_rd_o,
  // bit space access
  output reg [7:0] bit_addr_o,
  output reg bit_rd_o,
  // core state kept here
  output reg [W-1:0] acc_o,
  output reg [7:0] sp_o,
  output reg [7:0] psw_o
);

  // sequencer states
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_EX1 = 2'b01;
  localparam [1:0] S_EX2 = 2'b10;

  // instruction classes
  localparam [2:0] C_ACC_REG = 3'd0;
  localparam [2:0] C_ACC_DIR = 3'd1;
  localparam [2:0] C_ACC_IND = 3'd2;
  localparam [2:0] C_ACC_IMM = 3'd3;
  localparam [2:0] C_DIR_IMM = 3'd4;
  localparam [2:0] C_C_BIT = 3'd5;
  localparam [2:0] C_C_NBIT = 3'd6;
  localparam [2:0] C_POP = 3'd7;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] cls_q;
  reg [2:0] cls_d;
  reg [7:0] imm_q;
  reg [7:0] imm_d;
  reg [W-1:0] acc_d;
  reg [7:0] sp_d;
  reg [7:0] psw_d;
  reg busy_d;
  reg done_d;
  reg illegal_d;
  reg [7:0] dir_addr_d;
  reg dir_rd_d;
  reg dir_latch_d;
  reg dir_wr_d;
  reg [W-1:0] dir_wdata_d;
  reg [7:0] ram_addr_d;
  reg ram_rd_d;
  reg [7:0] bit_addr_d;
  reg bit_rd_d;
  reg [W-1:0] dir_val;
  reg [W-1:0] bit_src;
  reg [W-1:0] or_b;
  reg wr_go;
  reg [W-1:0] wr_val;
  wire [W-1:0] or_res;
  wire bit_val;
  wire [7:0] bit_byte_addr;

  // byte that holds the addressed bit; low bit addresses live in ram 20h-2fh
  assign bit_byte_addr = (bit_addr_o >= `OASP_BIT_SFR_BASE) ?
                         {bit_addr_o[7:3], 3'b000} : {4'h2, bit_addr_o[6:3]};

  // direct reads of state held here bypass the outside direct space
  always @* begin
    if (dir_addr_o == `OASP_ADDR_ACC) begin
      dir_val = acc_o;
    end else if (dir_addr_o == `OASP_ADDR_SP) begin
      dir_val = sp_o;
    end else if (dir_addr_o == `OASP_ADDR_PSW) begin
      dir_val = psw_o;
    end else begin
      dir_val = dir_rdata_i;
    end
  end

  // bit operand source byte, again internal state first
  always @* begin
    if (bit_byte_addr == `OASP_ADDR_ACC) begin
      bit_src = acc_o;
    end else if (bit_byte_addr == `OASP_ADDR_PSW) begin
      bit_src = psw_o;
    end else begin
      bit_src = bit_byte_i;
    end
  end

  // second or operand depends on the addressing form
  always @* begin
    case (cls_q)
      C_ACC_IND: or_b = ram_rdata_i;
      C_ACC_IMM: or_b = imm_q;
      C_DIR_IMM: or_b = imm_q;
      default: or_b = dir_val;
    endcase
  end

  // shared or datapath and bit picker
  oasp_alu #(
    .W(W)
  ) u_alu (
    .opa_i(cls_q == C_DIR_IMM ? dir_val : acc_o),
    .opb_i(or_b),
    .bit_byte_i(bit_src),
    .bit_sel_i(bit_addr_o[2:0]),
    .bit_inv_i(cls_q == C_C_NBIT),
    .or_res_o(or_res),
    .bit_val_o(bit_val)
  );

  // next-state and datapath decisions
  always @* begin
    state_d = state_q;
    cls_d = cls_q;
    imm_d = imm_q;
    acc_d = acc_o;
    sp_d = sp_o;
    psw_d = psw_o;
    busy_d = busy_o;
    done_d = 1'b0;
    illegal_d = 1'b0;
    dir_addr_d = dir_addr_o;
    dir_rd_d = 1'b0;
    dir_latch_d = 1'b0;
    dir_wr_d = 1'b0;
    dir_wdata_d = dir_wdata_o;
    ram_addr_d = ram_addr_o;
    ram_rd_d = 1'b0;
    bit_addr_d = bit_addr_o;
    bit_rd_d = 1'b0;
    wr_go = 1'b0;
    wr_val = or_res;
    case (state_q)
      S_IDLE: begin
        if (start_i) begin
          imm_d = byte3_i;
          state_d = S_EX1;
          busy_d = 1'b1;
          // decode and present the operand fetch for the next cycle
          if (opcode_i[7:3] == `OASP_OP_ACC_REG_HI) begin
            cls_d = C_ACC_REG;
            dir_addr_d = {3'b000, psw_o[`OASP_PSW_RS_HI:`OASP_PSW_RS_LO], opcode_i[2:0]};
            dir_rd_d = 1'b1;
          end else if (opcode_i == `OASP_OP_ACC_DIR) begin
            cls_d = C_ACC_DIR;
            dir_addr_d = byte2_i;
            dir_rd_d = 1'b1;
          end else if (opcode_i[7:1] == `OASP_OP_ACC_IND_HI) begin
            cls_d = C_ACC_IND;
            ram_addr_d = opcode_i[0] ? ptr1_i : ptr0_i;
            ram_rd_d = 1'b1;
          end else if (opcode_i == `OASP_OP_ACC_IMM) begin
            cls_d = C_ACC_IMM;
            imm_d = byte2_i;
          end else if (opcode_i == `OASP_OP_DIR_IMM) begin
            cls_d = C_DIR_IMM;
            dir_addr_d = byte2_i;
            dir_rd_d = 1'b1;
            dir_latch_d = 1'b1;
          end else if (opcode_i == `OASP_OP_C_BIT) begin
            cls_d = C_C_BIT;
            bit_addr_d = byte2_i;
            bit_rd_d = 1'b1;
          end else if (opcode_i == `OASP_OP_C_NBIT) begin
            cls_d = C_C_NBIT;
            bit_addr_d = byte2_i;
            bit_rd_d = 1'b1;
          end else if (opcode_i == `OASP_OP_POP) begin
            cls_d = C_POP;
            ram_addr_d = sp_o;
            ram_rd_d = 1'b1;
            dir_addr_d = byte2_i;
          end else begin
            // not ours: flag it and stay idle so the core can route it
            state_d = S_IDLE;
            busy_d = 1'b0;
            illegal_d = 1'b1;
          end
        end
      end
      S_EX1: begin
        case (cls_q)
          C_DIR_IMM: begin
            wr_go = 1'b1;
            state_d = S_EX2;
          end
          C_C_BIT, C_C_NBIT: begin
            // carry can only be set here; a zero source leaves it alone
            if (bit_val) begin
              psw_d[`OASP_PSW_CY] = 1'b1;
            end
            state_d = S_EX2;
          end
          C_POP: begin
            sp_d = sp_o - 8'h01;
            wr_go = 1'b1;
            wr_val = ram_rdata_i;
            state_d = S_EX2;
          end
          default: begin
            // accumulator forms finish here
            acc_d = or_res;
            done_d = 1'b1;
            busy_d = 1'b0;
            state_d = S_IDLE;
          end
        endcase
      end
      S_EX2: begin
        // second cycle of two-cycle forms; the outside write lands here
        done_d = 1'b1;
        busy_d = 1'b0;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
        busy_d = 1'b0;
      end
    endcase
    // destination write; pointer load overrides the decrement above
    if (wr_go) begin
      if (dir_addr_o == `OASP_ADDR_ACC) begin
        acc_d = wr_val;
      end else if (dir_addr_o == `OASP_ADDR_SP) begin
        sp_d = wr_val;
      end else if (dir_addr_o == `OASP_ADDR_PSW) begin
        psw_d = wr_val;
      end else begin
        dir_wr_d = 1'b1;
        dir_wdata_d = wr_val;
      end
    end
    // parity always follows the accumulator and nothing else
    psw_d[`OASP_PSW_P] = ^acc_d;
  end

  // state registers; all frozen while the clock enable is low, except that the synchronous reset still loads them
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      state_q <= S_IDLE;
      cls_q <= C_ACC_REG;
      imm_q <= 8'h00;
      acc_o <= `OASP_RST_ACC;
      sp_o <= `OASP_RST_SP;
      psw_o <= `OASP_RST_PSW;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      dir_addr_o <= 8'h00;
      dir_rd_o <= 1'b0;
      dir_latch_o <= 1'b0;
      dir_wr_o <= 1'b0;
      dir_wdata_o <= {W{1'b0}};
      ram_addr_o <= 8'h00;
      ram_rd_o <= 1'b0;
      bit_addr_o <= 8'h00;
      bit_rd_o <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      cls_q <= cls_d;
      imm_q <= imm_d;
      acc_o <= acc_d;
      sp_o <= sp_d;
      psw_o <= psw_d;
      busy_o <= busy_d;
      done_o <= done_d;
      illegal_o <= illegal_d;
      dir_addr_o <= dir_addr_d;
      dir_rd_o <= dir_rd_d;
      dir_latch_o <= dir_latch_d;
      dir_wr_o <= dir_wr_d;
      dir_wdata_o <= dir_wdata_d;
      ram_addr_o <= ram_addr_d;
      ram_rd_o <= ram_rd_d;
      bit_addr_o <= bit_addr_d;
      bit_rd_o <= bit_rd_d;
    end
  end

endmodule

// ===== test/oasp_props.sv
// assertion checker for the or / carry-or / stack pull execute unit
// assumes it is bound to oasp_exec and sees only its ports
`timescale 1ns/1ps
module oasp_props #(
  parameter W = 8
) (
  // clock, reset and issue
  input wire clock_i, nrst_i, ce_i, start_i,
  input wire [7:0] opcode_i, byte2_i, byte3_i,
  // read answers
  input wire [W-1:0] ptr0_i, ptr1_i, dir_rdata_i, ram_rdata_i, bit_byte_i,
  // status and strobes
  input wire busy_o, done_o, illegal_o, dir_rd_o, dir_latch_o, dir_wr_o, ram_rd_o, bit_rd_o,
  input wire [7:0] dir_addr_o, ram_addr_o, bit_addr_o, sp_o, psw_o,
  input wire [W-1:0] dir_wdata_o, acc_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // accepted requests by class
  wire tk = start_i && !busy_o && ce_i;
  wire pop = tk && opcode_i == 8'hd0;
  wire cor = tk && (opcode_i == 8'h72 || opcode_i == 8'ha0);
  wire dimm = tk && opcode_i == 8'h43;
  wire accf = tk && (opcode_i[7:3] == 5'h09 || opcode_i[7:1] == 7'h23 || opcode_i[7:1] == 7'h22);
  wire inw = byte2_i == 8'he0 || byte2_i == 8'h81 || byte2_i == 8'hd0;
  // remember the complement form, the bit read comes a cycle after the take
  reg inv_q;
  always @(posedge clock_i) begin
    if (cor) inv_q <= opcode_i[7];
  end
  a_acc_one_cycle: assert property (accf |-> ##1 !done_o ##1 done_o) else $error("acc or late");
  a_long_two_cycles: assert property ((pop || cor || dimm) |-> ##1 !done_o ##1 !done_o ##1 done_o)
    else $error("long form timing");
  a_pop_reads_sp: assert property (pop |-> ##1 ram_rd_o && ram_addr_o == $past(sp_o))
    else $error("pop read address");
  a_pop_dec_sp: assert property (pop && byte2_i != 8'h81 |-> ##2 sp_o == $past(sp_o, 2) - 8'h01)
    else $error("pop pointer step");
  a_pop_into_sp: assert property (pop && byte2_i == 8'h81 |-> ##2 sp_o == $past(ram_rdata_i))
    else $error("pop into pointer");
  a_pop_keeps_flags: assert property (pop && byte2_i != 8'hd0 |-> ##2 (psw_o >> 1) == ($past(psw_o, 2) >> 1))
    else $error("pop changed flags");
  a_cor_only_sets: assert property (cor |-> ##2 (psw_o | 8'h80) == ($past(psw_o, 2) | 8'h80) && psw_o >= $past(psw_o, 2))
    else $error("carry or side effect");
  a_cor_sets_carry: assert property (bit_rd_o && (bit_byte_i[bit_addr_o[2:0]] ^ inv_q) |-> ##1 psw_o[7])
    else $error("carry not set");
  a_acc_or_value: assert property (dir_rd_o && !dir_latch_o && dir_addr_o < 8'h80 |-> ##1 acc_o == ($past(acc_o) | $past(dir_rdata_i)))
    else $error("acc or value");
  a_parity_acc: assert property (psw_o[0] == ^acc_o) else $error("parity wrong");
  a_dir_latch: assert property (dimm |-> ##1 dir_rd_o && dir_latch_o && dir_addr_o == $past(byte2_i))
    else $error("latch read missing");
  a_dir_write: assert property (dimm && !inw |-> ##2 dir_wr_o && dir_wdata_o == ($past(dir_rdata_i) | $past(byte3_i, 2)))
    else $error("direct write wrong");
  c_pop_sp: cover property (pop && byte2_i == 8'h81);
  c_cor_inv: cover property (bit_rd_o && inv_q);
  c_dir_wr: cover property (dir_wr_o);
endmodule

bind oasp_exec oasp_props #(.W(W)) i_oasp_props (.*);

// ===== test/test_or_and_stack_pull_exec.sv
// self-checking bench for the or / carry-or / stack pull execute unit
// assumes the read answers may be combinational in the strobe cycle
`timescale 1ns/1ps
module test_or_and_stack_pull_exec;
  reg clock_i = 0, nrst_i = 0, ce_i = 1, start_i = 0;
  reg [7:0] opcode_i = 0, byte2_i = 0, byte3_i = 0, ptr0_i = 8'h10, ptr1_i = 8'h31;
  reg [7:0] dm = 0, rm = 0, bb = 0, wa = 0, wd = 0;
  integer errors = 0, tests_run = 0, cyc = 0, k;
  wire busy_o, done_o, illegal_o, dir_rd_o, dir_latch_o, dir_wr_o, ram_rd_o, bit_rd_o;
  wire [7:0] dir_addr_o, dir_wdata_o, ram_addr_o, bit_addr_o, acc_o, sp_o, psw_o;
  // read answers flip outside the strobe so stale data never looks valid
  wire [7:0] dir_rdata_i = dir_rd_o ? dm : ~dm;
  wire [7:0] ram_rdata_i = ram_rd_o ? rm : ~rm;
  wire [7:0] bit_byte_i = bit_rd_o ? bb : ~bb;
  oasp_exec #(.W(8)) i_oasp_exec (.*);
  always #50 clock_i = ~clock_i;
  // capture direct writes and cut a hang short
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (dir_wr_o) begin
      wa <= dir_addr_o;
      wd <= dir_wdata_o;
    end
    if (cyc == 2000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  task chk(input [7:0] g, input [7:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // issue one instruction, count edges from take to done
  task run(input [7:0] o, input [7:0] x, input [7:0] y, input integer n);
    opcode_i = o;
    byte2_i = x;
    byte3_i = y;
    start_i = 1;
    @(posedge clock_i);
    #1 start_i = 0;
    k = 1;
    while (done_o !== 1'b1 && k < 9) begin
      @(posedge clock_i);
      #1 k = k + 1;
    end
    chk(k[7:0], n[7:0]);
  endtask
  task t_acc;
    run(8'h44, 8'hc3, 8'h00, 2);
    chk(acc_o, 8'hc3);
    dm = 8'h55;
    run(8'h48, 8'h00, 8'h00, 2);
    chk(acc_o, 8'hd7);
    rm = 8'h08;
    run(8'h46, 8'h00, 8'h00, 2);
    chk(psw_o, 8'h01);
    dm = 8'h20;
    run(8'h45, 8'h30, 8'h00, 2);
    chk(acc_o, 8'hff);
    $display("test acc forms done");
  endtask
  task t_dir;
    dm = 8'h41;
    run(8'h43, 8'h90, 8'h32, 3);
    chk(wa, 8'h90);
    chk(wd, 8'h73);
    chk(psw_o, 8'h00);
    $display("test direct or done");
  endtask
  task t_cor;
    bb = 8'h00;
    run(8'h72, 8'h08, 8'h00, 3);
    chk(psw_o, 8'h00);
    bb = 8'h01;
    run(8'h72, 8'h08, 8'h00, 3);
    chk(psw_o, 8'h80);
    bb = 8'hff;
    run(8'ha0, 8'h08, 8'h00, 3);
    chk(psw_o, 8'h80);
    $display("test carry or done");
  endtask
  task t_pop;
    rm = 8'h5a;
    run(8'hd0, 8'h90, 8'h00, 3);
    chk(wd, 8'h5a);
    chk(sp_o, 8'h06);
    chk(psw_o, 8'h80);
    rm = 8'h00;
    run(8'hd0, 8'hd0, 8'h00, 3);
    chk(psw_o, 8'h00);
    bb = 8'hfe;
    run(8'ha0, 8'h08, 8'h00, 3);
    chk(psw_o, 8'h80);
    rm = 8'h20;
    run(8'hd0, 8'h81, 8'h00, 3);
    chk(sp_o, 8'h20);
    $display("test pull done");
  endtask
  // unknown opcode, mid-run reset and a frozen clock enable
  task t_misc;
    opcode_i = 8'h00;
    start_i = 1;
    @(posedge clock_i);
    #1 start_i = 0;
    chk({7'h00, illegal_o}, 8'h01);
    chk({7'h00, busy_o}, 8'h00);
    @(posedge clock_i);
    #1 chk({7'h00, illegal_o}, 8'h00);
    nrst_i = 0;
    @(posedge clock_i);
    #1 nrst_i = 1;
    chk(acc_o, 8'h00);
    chk(sp_o, 8'h07);
    opcode_i = 8'h44;
    byte2_i = 8'h0f;
    start_i = 1;
    ce_i = 0;
    @(posedge clock_i);
    #1 chk({7'h00, busy_o}, 8'h00);
    ce_i = 1;
    @(posedge clock_i);
    #1 start_i = 0;
    chk({7'h00, busy_o}, 8'h01);
    @(posedge clock_i);
    #1 chk({7'h00, done_o}, 8'h01);
    chk(acc_o, 8'h0f);
    $display("test misc done");
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    #1 nrst_i = 1;
    t_acc;
    t_dir;
    t_cor;
    t_pop;
    t_misc;
    end_of_test;
  end
endmodule
